// ---- ctrl_pkg.sv ----
// constants and types for the clock translator control register bank
package ctrl_pkg;
  localparam int unsigned CTRL_ADDR_W = 16;
  localparam int unsigned CTRL_DATA_W = 8;
  // register offsets
  localparam logic [15:0] CTRL_UPDATE_TRANSFER = 16'h0005;
  localparam logic [15:0] CTRL_IRQ_PIN_MODE = 16'h0209;
  localparam logic [15:0] CTRL_IRQ_MASK_BASE = 16'h020a;
  localparam logic [15:0] CTRL_WDOG_LO = 16'h0210;
  localparam logic [15:0] CTRL_WDOG_HI = 16'h0211;
  localparam logic [15:0] CTRL_OUTPUT_PLL_CALIBRATION = 16'h0405;
  localparam logic [15:0] CTRL_DISTRIBUTION_SYNC_CONTROL = 16'h0500;
  localparam logic [15:0] CTRL_DIST_LAST = 16'h0509;
  localparam logic [15:0] CTRL_LOOP_MODE_CONTROL = 16'h0a01;
  localparam logic [15:0] CTRL_SOFT_SYNC_CONTROL = 16'h0a02;
  localparam logic [15:0] CTRL_GLOBAL_CLEAR_CONTROL = 16'h0a03;
  localparam logic [15:0] CTRL_IRQ_CLEAR_BASE = 16'h0a04;
  localparam logic [15:0] CTRL_PLL_LOCK_STATUS = 16'h0d01;
  localparam logic [15:0] CTRL_IRQ_MONITOR_BASE = 16'h0d02;
  localparam int unsigned CTRL_IRQ_BYTES = 6;
  // buffered register slots
  localparam int unsigned CTRL_NBUF = 21;
  localparam int unsigned CTRL_SLOT_CAL = 0;
  localparam int unsigned CTRL_SLOT_LOOP = 1;
  localparam int unsigned CTRL_SLOT_PINMODE = 2;
  localparam int unsigned CTRL_SLOT_MASK = 3;
  localparam int unsigned CTRL_SLOT_WDOG = 9;
  localparam int unsigned CTRL_SLOT_DIST = 11;
  // field positions
  localparam int unsigned CTRL_UPDATE_BIT = 0;
  localparam int unsigned CTRL_CAL_BIT = 0;
  localparam int unsigned CTRL_FREERUN_BIT = 5;
  localparam int unsigned CTRL_SOFT_SYNC_BIT = 1;
  localparam int unsigned CTRL_CLR_ALL_BIT = 1;
  localparam int unsigned CTRL_WDOG_CLR_BIT = 0;
  localparam int unsigned CTRL_PLL_LOCK_BIT = 2;
  localparam int unsigned CTRL_CHAN_EN_LSB = 4;
  localparam int unsigned CTRL_WDOG_EVT_BYTE = 5;
  localparam int unsigned CTRL_WDOG_EVT_BIT = 0;
  // reset values
  localparam logic [7:0] CTRL_LOOP_RESET = 8'h20;
  localparam logic [7:0] CTRL_MASK_RESET = 8'h00;
  localparam logic [7:0] CTRL_ZERO = 8'h00;
  // sync modes in the low two bits of the distribution sync register
  typedef enum logic [1:0] {
    CTRL_SYNC_MANUAL = 2'h0,
    CTRL_SYNC_PHASE_LOCK = 2'h1,
    CTRL_SYNC_FREQ_LOCK = 2'h2,
    CTRL_SYNC_MANUAL_ALT = 2'h3
  } ctrl_sync_mode_t;
  // interrupt pin drive modes
  typedef enum logic [1:0] {
    CTRL_IRQ_OD_NMOS = 2'h0,
    CTRL_IRQ_OD_PMOS = 2'h1,
    CTRL_IRQ_PP_HIGH = 2'h2,
    CTRL_IRQ_PP_LOW = 2'h3
  } ctrl_irq_mode_t;
  typedef enum logic [0:0] {
    CTRL_UPD_IDLE = 1'b0,
    CTRL_UPD_XFER = 1'b1
  } ctrl_upd_state_t;
  // timing
  localparam int unsigned CTRL_CLK_PERIOD_NS = 50;
  localparam int unsigned CTRL_MS_NS = 1000000;
  localparam int unsigned CTRL_MS_CYCLES = CTRL_MS_NS / CTRL_CLK_PERIOD_NS;
  localparam int unsigned CTRL_RF_DIV_MIN = 3;
  localparam int unsigned CTRL_RF_DIV_MAX = 11;
  localparam int unsigned CTRL_AVG_SHIFT = 4;
endpackage : ctrl_pkg

// ---- ctrl_regs.sv ----
// control and status register bank of the clock translator
// Overview of operation
// - calibration starts only on a zero-to-one change of the active calibration bit.
// - output multiplier lock shows in bit 2 of the lock status register.
// - written settings except the soft sync bit become active only on an I/O update write.
// - phase or frequency lock sync modes release outputs automatically on lock.
// - other modes release outputs after a soft sync set-clear or pin pulse.
// - a masked-in event sets its interrupt monitor bit.
// - clearing registers clear single monitor bits; clear-all bit clears every one.
// - masks reset to no interrupts; interrupt pin resets to open-drain NMOS.
// - watchdog resets disabled; its period lives in two registers.
// - enabled watchdog raises an event on timeout and restarts on clear.
// - leaving free run via update acquires the highest-priority valid reference.
// - holdover output is a time average of tuning words before holdover.
// - two RF dividers of three to eleven feed 10-bit channel dividers.
// - six drivers in four channels, one, two, two and one drivers.
// - divider updates are accepted while the loop stays locked.
// - serial port is SPI when both select pins low after reset, else I2C.
`timescale 1ns/1ps
module ctrl_regs
  import ctrl_pkg::*;
#(
  parameter int unsigned P_MS_CYCLES = ctrl_pkg::CTRL_MS_CYCLES
) (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic [ctrl_pkg::CTRL_ADDR_W-1:0] i_reg_addr,
  input wire logic [ctrl_pkg::CTRL_DATA_W-1:0] i_reg_wdata,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  output logic [ctrl_pkg::CTRL_DATA_W-1:0] o_reg_rdata,
  input wire logic i_interface_select_pin_hi,
  input wire logic i_interface_select_pin_lo,
  output logic o_spi_mode,
  input wire logic i_output_multiplier_pll_locked,
  output logic o_cal_start,
  output logic o_cal_enabled,
  input wire logic i_dpll_phase_lock,
  input wire logic i_dpll_freq_lock,
  input wire logic i_mfp_sync,
  output logic o_dist_release,
  output logic [3:0] o_rf_div_a,
  output logic [3:0] o_rf_div_b,
  output logic [43:0] o_chan_div,
  output logic [5:0] o_drv_en,
  input wire logic [47:0] i_irq_events,
  output logic o_irq,
  output logic o_irq_oe,
  output logic o_user_freerun,
  input wire logic [3:0] i_ref_valid,
  input wire logic [11:0] i_ref_priority,
  output logic [1:0] o_active_ref,
  output logic o_ref_acquired,
  input wire logic i_holdover,
  input wire logic i_sysclk_present,
  input wire logic [29:0] i_dco_tw,
  output logic [29:0] o_dco_tw,
  output logic o_out_active
);
  import ctrl_pkg::*;

  // maps an address to a buffered slot, or returns -1
  function automatic int buf_slot(input logic [15:0] a);
    if (a == CTRL_OUTPUT_PLL_CALIBRATION) return CTRL_SLOT_CAL;
    if (a == CTRL_LOOP_MODE_CONTROL) return CTRL_SLOT_LOOP;
    if (a == CTRL_IRQ_PIN_MODE) return CTRL_SLOT_PINMODE;
    if (a >= CTRL_IRQ_MASK_BASE && a < CTRL_WDOG_LO)
      return CTRL_SLOT_MASK + int'(a - CTRL_IRQ_MASK_BASE);
    if (a == CTRL_WDOG_LO || a == CTRL_WDOG_HI)
      return CTRL_SLOT_WDOG + int'(a - CTRL_WDOG_LO);
    if (a >= CTRL_DISTRIBUTION_SYNC_CONTROL && a <= CTRL_DIST_LAST)
      return CTRL_SLOT_DIST + int'(a - CTRL_DISTRIBUTION_SYNC_CONTROL);
    return -1;
  endfunction : buf_slot

  // clamps an RF divider ratio into its legal span
  function automatic logic [3:0] rf_clamp(input logic [3:0] v);
    if (v < 4'(CTRL_RF_DIV_MIN)) return 4'(CTRL_RF_DIV_MIN);
    if (v > 4'(CTRL_RF_DIV_MAX)) return 4'(CTRL_RF_DIV_MAX);
    return v;
  endfunction : rf_clamp

  // register access and update transfer
  logic [7:0] pend_q [CTRL_NBUF];
  logic [7:0] pend_d [CTRL_NBUF];
  logic [7:0] act_q [CTRL_NBUF];
  logic [7:0] act_d [CTRL_NBUF];
  ctrl_upd_state_t upd_q;
  ctrl_upd_state_t upd_d;
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;
  logic soft_sync_q;
  logic soft_sync_d;
  logic clr_all;
  logic wdog_clr;
  logic [47:0] clr_bits;
  logic [47:0] mon_q;
  logic [47:0] mon_d;
  logic [47:0] mask_vec;
  int slot;

  always_comb
  begin
    slot = buf_slot(i_reg_addr);
    pend_d = pend_q;
    act_d = act_q;
    upd_d = upd_q;
    rdata_d = rdata_q;
    soft_sync_d = soft_sync_q;
    clr_all = 1'b0;
    wdog_clr = 1'b0;
    clr_bits = '0;
    if (i_reg_wr)
    begin
      if (slot >= 0)
        pend_d[slot] = i_reg_wdata;
      if (i_reg_addr == CTRL_UPDATE_TRANSFER && i_reg_wdata[CTRL_UPDATE_BIT])
        upd_d = CTRL_UPD_XFER;
      if (i_reg_addr == CTRL_SOFT_SYNC_CONTROL)
        soft_sync_d = i_reg_wdata[CTRL_SOFT_SYNC_BIT];
      if (i_reg_addr == CTRL_GLOBAL_CLEAR_CONTROL)
      begin
        clr_all = i_reg_wdata[CTRL_CLR_ALL_BIT];
        wdog_clr = i_reg_wdata[CTRL_WDOG_CLR_BIT];
      end
      if (i_reg_addr >= CTRL_IRQ_CLEAR_BASE &&
          i_reg_addr < CTRL_IRQ_CLEAR_BASE + 16'(CTRL_IRQ_BYTES))
        clr_bits[8*(i_reg_addr-CTRL_IRQ_CLEAR_BASE) +: 8] = i_reg_wdata;
    end
    // transfer takes one cycle; divider changes pass regardless of lock
    if (upd_q == CTRL_UPD_XFER)
    begin
      act_d = pend_q;
      upd_d = CTRL_UPD_IDLE;
    end
    if (i_reg_rd)
    begin
      rdata_d = CTRL_ZERO;
      if (slot >= 0)
        rdata_d = pend_q[slot];
      else if (i_reg_addr == CTRL_UPDATE_TRANSFER)
        rdata_d = {7'h00, upd_q == CTRL_UPD_XFER};
      else if (i_reg_addr == CTRL_SOFT_SYNC_CONTROL)
        rdata_d = 8'(soft_sync_q) << CTRL_SOFT_SYNC_BIT;
      else if (i_reg_addr == CTRL_PLL_LOCK_STATUS)
        rdata_d = 8'(i_output_multiplier_pll_locked) << CTRL_PLL_LOCK_BIT;
      else if (i_reg_addr >= CTRL_IRQ_MONITOR_BASE &&
               i_reg_addr < CTRL_IRQ_MONITOR_BASE + 16'(CTRL_IRQ_BYTES))
        rdata_d = mon_q[8*(i_reg_addr-CTRL_IRQ_MONITOR_BASE) +: 8];
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_rstn)
    begin
      for (int k = 0; k < CTRL_NBUF; k++)
      begin
        pend_q[k] <= CTRL_MASK_RESET;
        act_q[k] <= CTRL_MASK_RESET;
      end
      pend_q[CTRL_SLOT_LOOP] <= CTRL_LOOP_RESET;
      act_q[CTRL_SLOT_LOOP] <= CTRL_LOOP_RESET;
      upd_q <= CTRL_UPD_IDLE;
      rdata_q <= CTRL_ZERO;
      soft_sync_q <= 1'b0;
    end
    else
    begin
      pend_q <= pend_d;
      act_q <= act_d;
      upd_q <= upd_d;
      rdata_q <= rdata_d;
      soft_sync_q <= soft_sync_d;
    end
  end

  assign o_reg_rdata = rdata_q;

  // interface select strap, caught on the first edge after release
  logic strap_done_q;
  logic strap_done_d;
  logic spi_q;
  logic spi_d;
  always_comb
  begin
    strap_done_d = 1'b1;
    spi_d = spi_q;
    if (!strap_done_q)
      spi_d = !i_interface_select_pin_hi && !i_interface_select_pin_lo;
  end

  // calibration edge, watchdog, interrupt monitor
  logic cal_prev_q;
  logic [14:0] ms_cnt_q;
  logic [14:0] ms_cnt_d;
  logic [15:0] wd_cnt_q;
  logic [15:0] wd_cnt_d;
  logic [15:0] wd_period;
  logic wd_evt;
  logic [47:0] events;
  always_comb
  begin
    for (int b = 0; b < CTRL_IRQ_BYTES; b++)
      mask_vec[8*b +: 8] = act_q[CTRL_SLOT_MASK + b];
    wd_period = {act_q[CTRL_SLOT_WDOG + 1], act_q[CTRL_SLOT_WDOG]};
    ms_cnt_d = ms_cnt_q;
    wd_cnt_d = wd_cnt_q;
    wd_evt = 1'b0;
    // a zero period keeps the watchdog disabled
    if (wd_period == 16'h0000 || wdog_clr)
    begin
      ms_cnt_d = '0;
      wd_cnt_d = '0;
    end
    else if (ms_cnt_q == 15'(P_MS_CYCLES - 1))
    begin
      ms_cnt_d = '0;
      if (wd_cnt_q + 16'h0001 >= wd_period)
      begin
        wd_evt = 1'b1;
        wd_cnt_d = '0;
      end
      else
        wd_cnt_d = wd_cnt_q + 16'h0001;
    end
    else
      ms_cnt_d = ms_cnt_q + 15'h0001;
    events = i_irq_events;
    events[8*CTRL_WDOG_EVT_BYTE + CTRL_WDOG_EVT_BIT] =
      i_irq_events[8*CTRL_WDOG_EVT_BYTE + CTRL_WDOG_EVT_BIT] | wd_evt;
    // a new event beats a clear in the same cycle; bits hold otherwise
    mon_d = mon_q & ~clr_bits;
    if (clr_all)
      mon_d = '0;
    mon_d = mon_d | (events & mask_vec);
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_rstn)
    begin
      strap_done_q <= 1'b0;
      spi_q <= 1'b0;
      cal_prev_q <= 1'b0;
      ms_cnt_q <= '0;
      wd_cnt_q <= '0;
      mon_q <= '0;
    end
    else
    begin
      strap_done_q <= strap_done_d;
      spi_q <= spi_d;
      cal_prev_q <= act_q[CTRL_SLOT_CAL][CTRL_CAL_BIT];
      ms_cnt_q <= ms_cnt_d;
      wd_cnt_q <= wd_cnt_d;
      mon_q <= mon_d;
    end
  end

  assign o_spi_mode = spi_q;
  // the bit is never cleared here, so a second start needs a host clear first
  assign o_cal_start = act_q[CTRL_SLOT_CAL][CTRL_CAL_BIT] & ~cal_prev_q;
  assign o_cal_enabled = act_q[CTRL_SLOT_CAL][CTRL_CAL_BIT];

  // interrupt pin drive
  ctrl_irq_mode_t irq_mode;
  logic irq_any;
  always_comb
  begin
    irq_mode = ctrl_irq_mode_t'(act_q[CTRL_SLOT_PINMODE][1:0]);
    irq_any = |mon_q;
    unique case (irq_mode)
      CTRL_IRQ_OD_NMOS:
      begin
        o_irq = 1'b0;
        o_irq_oe = irq_any;
      end
      CTRL_IRQ_OD_PMOS:
      begin
        o_irq = 1'b1;
        o_irq_oe = irq_any;
      end
      CTRL_IRQ_PP_HIGH:
      begin
        o_irq = irq_any;
        o_irq_oe = 1'b1;
      end
      CTRL_IRQ_PP_LOW:
      begin
        o_irq = ~irq_any;
        o_irq_oe = 1'b1;
      end
    endcase
  end

  // distribution sync, dividers, driver enables
  ctrl_sync_mode_t sync_mode;
  logic rel_q;
  logic rel_d;
  logic soft_prev_q;
  logic [3:0] chan_en;
  always_comb
  begin
    sync_mode = ctrl_sync_mode_t'(act_q[CTRL_SLOT_DIST][1:0]);
    rel_d = rel_q;
    unique case (sync_mode)
      CTRL_SYNC_PHASE_LOCK: rel_d = i_dpll_phase_lock;
      CTRL_SYNC_FREQ_LOCK: rel_d = i_dpll_freq_lock;
      CTRL_SYNC_MANUAL, CTRL_SYNC_MANUAL_ALT:
      begin
        // outputs stay static while the soft sync bit is held high
        if (soft_sync_q)
          rel_d = 1'b0;
        else if ((soft_prev_q && !soft_sync_q) || i_mfp_sync)
          rel_d = 1'b1;
      end
    endcase
    chan_en = act_q[CTRL_SLOT_DIST][CTRL_CHAN_EN_LSB +: 4];
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_rstn)
    begin
      rel_q <= 1'b0;
      soft_prev_q <= 1'b0;
      o_rf_div_a <= 4'(CTRL_RF_DIV_MIN);
      o_rf_div_b <= 4'(CTRL_RF_DIV_MIN);
      o_chan_div <= '0;
      o_drv_en <= '0;
    end
    else
    begin
      rel_q <= rel_d;
      soft_prev_q <= soft_sync_q;
      o_rf_div_a <= rf_clamp(act_q[CTRL_SLOT_DIST + 1][3:0]);
      o_rf_div_b <= rf_clamp(act_q[CTRL_SLOT_DIST + 1][7:4]);
      // channel ratio is the 10-bit field plus one, so 1 through 1024
      for (int c = 0; c < 4; c++)
        o_chan_div[11*c +: 11] <= {1'b0, act_q[CTRL_SLOT_DIST + 3 + 2*c][1:0],
          act_q[CTRL_SLOT_DIST + 2 + 2*c]} + 11'h001;
      o_drv_en <= {chan_en[3], {2{chan_en[2]}}, {2{chan_en[1]}}, chan_en[0]}
        & {6{rel_q}};
    end
  end

  assign o_dist_release = rel_q;

  // reference acquisition and holdover averaging
  logic [1:0] best;
  logic best_ok;
  logic [33:0] avg_q;
  logic [33:0] avg_d;
  logic [1:0] ref_q;
  logic [1:0] ref_d;
  logic acq_q;
  logic acq_d;
  logic freerun;
  always_comb
  begin
    best = 2'h0;
    best_ok = 1'b0;
    // smaller priority value wins; lower index breaks a tie
    for (int r = 0; r < 4; r++)
      if (i_ref_valid[r] && (!best_ok ||
          i_ref_priority[3*r +: 3] < i_ref_priority[3*best +: 3]))
      begin
        best = 2'(r);
        best_ok = 1'b1;
      end
    freerun = act_q[CTRL_SLOT_LOOP][CTRL_FREERUN_BIT];
    ref_d = ref_q;
    acq_d = 1'b0;
    if (!freerun && best_ok)
    begin
      ref_d = best;
      acq_d = 1'b1;
    end
    // history freezes in holdover so the average reflects the time before it
    avg_d = avg_q;
    if (!i_holdover)
      avg_d = avg_q - (avg_q >> CTRL_AVG_SHIFT) + {4'h0, i_dco_tw};
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_rstn)
    begin
      ref_q <= 2'h0;
      acq_q <= 1'b0;
      avg_q <= '0;
      o_dco_tw <= '0;
      o_out_active <= 1'b0;
    end
    else
    begin
      ref_q <= ref_d;
      acq_q <= acq_d;
      avg_q <= avg_d;
      o_dco_tw <= i_holdover ? avg_q[33:4] : i_dco_tw;
      o_out_active <= i_sysclk_present;
    end
  end

  assign o_user_freerun = act_q[CTRL_SLOT_LOOP][CTRL_FREERUN_BIT];
  assign o_active_ref = ref_q;
  assign o_ref_acquired = acq_q;
endmodule : ctrl_regs

// ---- ctrl_regs_properties.sv ----
// port checks for the control register bank
`timescale 1ns/1ps
module ctrl_regs_properties
  import ctrl_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic [15:0] i_reg_addr,
  input wire logic [7:0] i_reg_wdata,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  input wire logic [7:0] o_reg_rdata,
  input wire logic i_interface_select_pin_hi,
  input wire logic i_interface_select_pin_lo,
  input wire logic o_spi_mode,
  input wire logic i_output_multiplier_pll_locked,
  input wire logic o_cal_start,
  input wire logic o_cal_enabled,
  input wire logic i_dpll_phase_lock,
  input wire logic i_dpll_freq_lock,
  input wire logic i_mfp_sync,
  input wire logic o_dist_release,
  input wire logic o_irq,
  input wire logic o_irq_oe,
  input wire logic o_user_freerun
);
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rstn);
  logic upd_wr;
  logic ss_clr;
  logic irq_clr;
  assign upd_wr = i_reg_wr && i_reg_addr == CTRL_UPDATE_TRANSFER && i_reg_wdata[0];
  assign ss_clr = i_reg_wr && i_reg_addr == CTRL_SOFT_SYNC_CONTROL && !i_reg_wdata[1];
  // clear-all and the six single clear registers form one address run
  assign irq_clr = i_reg_wr && i_reg_addr >= CTRL_GLOBAL_CLEAR_CONTROL
    && i_reg_addr <= 16'h0a09;
  cal_start_a: assert property (o_cal_start |-> o_cal_enabled && !$past(o_cal_enabled)
    && $past(upd_wr, 2))
    else $error("calibration start without a rising calibration bit");
  lock_status_a: assert property (i_reg_rd && i_reg_addr == CTRL_PLL_LOCK_STATUS |=>
    o_reg_rdata[CTRL_PLL_LOCK_BIT] == $past(i_output_multiplier_pll_locked))
    else $error("lock status bit wrong");
  update_clear_a: assert property (i_reg_rd && i_reg_addr == CTRL_UPDATE_TRANSFER
    && !upd_wr && !$past(upd_wr) && !$past(upd_wr, 2) |=> !o_reg_rdata[CTRL_UPDATE_BIT])
    else $error("update bit not self clearing");
  release_cause_a: assert property ($rose(o_dist_release) |-> $past(i_mfp_sync)
    || $past(i_mfp_sync, 2) || $past(i_dpll_phase_lock) || $past(i_dpll_freq_lock)
    || $past(ss_clr) || $past(ss_clr, 2) || $past(ss_clr, 3))
    else $error("outputs released without a cause");
  active_change_a: assert property ($changed(o_cal_enabled) || $changed(o_user_freerun)
    |-> $past(upd_wr) || $past(upd_wr, 2) || $past(upd_wr, 3))
    else $error("active setting changed without update");
  strap_mode_a: assert property ($rose(i_rstn) |-> ##2
    o_spi_mode == (!i_interface_select_pin_hi && !i_interface_select_pin_lo))
    else $error("serial mode does not match straps");
  irq_hold_a: assert property ($fell(o_irq_oe) |-> $past(irq_clr) || $past(irq_clr, 2))
    else $error("interrupt dropped without clear");
  irq_reset_a: assert property ($rose(i_rstn) |-> (!o_irq && !o_irq_oe) [*3])
    else $error("interrupt active after reset");
  cover property (o_cal_start);
  cover property ($rose(o_dist_release));
  cover property ($fell(o_irq_oe));
endmodule : ctrl_regs_properties

bind ctrl_regs ctrl_regs_properties i_ctrl_regs_properties (.i_clk(i_clk), .i_rstn(i_rstn),
  .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata), .i_reg_wr(i_reg_wr),
  .i_reg_rd(i_reg_rd), .o_reg_rdata(o_reg_rdata), .o_spi_mode(o_spi_mode),
  .i_interface_select_pin_hi(i_interface_select_pin_hi),
  .i_interface_select_pin_lo(i_interface_select_pin_lo),
  .i_output_multiplier_pll_locked(i_output_multiplier_pll_locked),
  .o_cal_start(o_cal_start), .o_cal_enabled(o_cal_enabled), .i_mfp_sync(i_mfp_sync),
  .i_dpll_phase_lock(i_dpll_phase_lock), .i_dpll_freq_lock(i_dpll_freq_lock),
  .o_dist_release(o_dist_release), .o_irq(o_irq), .o_irq_oe(o_irq_oe),
  .o_user_freerun(o_user_freerun));

// ---- ctrl_host.sv ----
// host model on the register access port
`timescale 1ns/1ps
module ctrl_host
  import ctrl_pkg::*;
(
  input wire logic i_clk,
  input wire logic [7:0] i_rdata,
  output logic [15:0] o_addr,
  output logic [7:0] o_wdata,
  output logic o_wr,
  output logic o_rd
);
  initial
  begin
    o_addr = 16'h0000;
    o_wdata = 8'h00;
    o_wr = 1'b0;
    o_rd = 1'b0;
  end
  // idle bus shows the inverted last value so a stale match cannot pass
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(negedge i_clk);
    o_addr = a;
    o_wdata = d;
    o_wr = 1'b1;
    @(negedge i_clk);
    o_wr = 1'b0;
    o_addr = ~a;
    o_wdata = ~d;
  endtask : wr
  task automatic rd(input logic [15:0] a, output logic [7:0] d);
    @(negedge i_clk);
    o_addr = a;
    o_rd = 1'b1;
    @(negedge i_clk);
    o_rd = 1'b0;
    o_addr = ~a;
    @(negedge i_clk);
    d = i_rdata;
  endtask : rd
  task automatic upd();
    wr(CTRL_UPDATE_TRANSFER, 8'h01);
    repeat (2) @(negedge i_clk);
  endtask : upd
  // caller keeps the system clock present before calibrating
  task automatic cal();
    wr(CTRL_OUTPUT_PLL_CALIBRATION, 8'h00);
    upd();
    wr(CTRL_OUTPUT_PLL_CALIBRATION, 8'h01);
    upd();
  endtask : cal
endmodule : ctrl_host

// ---- tb_top.sv ----
// self-checking bench for the control register bank
`timescale 1ns/1ps
module tb_top;
  import ctrl_pkg::*;
  localparam logic [29:0] TW = 30'h0abcdef0;
  localparam logic [5:0] DRV [4] = '{6'h01, 6'h06, 6'h18, 6'h20};
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic [15:0] addr;
  logic [7:0] wdata, rdata, d;
  logic wr, rd, spi, cal_start, cal_en, rel, irq, irq_oe, frun, acq, outact;
  logic lock = 1'b0;
  logic ph = 1'b0;
  logic fr = 1'b0;
  logic mfp = 1'b0;
  logic hold = 1'b0;
  logic sysclk = 1'b1;
  logic [1:0] strap = 2'b00;
  logic [47:0] ev = 48'h0;
  logic [3:0] rvalid = 4'h6;
  logic [11:0] rprio = {3'd1, 3'd2, 3'd5, 3'd0};
  logic [29:0] tw_in = TW;
  logic [29:0] tw_out;
  logic [3:0] rfa, rfb;
  logic [43:0] cdiv;
  logic [5:0] drv;
  logic [1:0] aref;
  int mismatches = 0;
  int n_checks = 0;
  int ncal = 0;
  always #25 clk = ~clk;
  always @(negedge clk) if (cal_start === 1'b1) ncal++;
  ctrl_host i_ctrl_host (.i_clk(clk), .i_rdata(rdata), .o_addr(addr), .o_wdata(wdata),
    .o_wr(wr), .o_rd(rd));
  // short millisecond keeps the watchdog test brief
  ctrl_regs #(.P_MS_CYCLES(10)) i_ctrl_regs (.i_clk(clk), .i_rstn(rstn), .i_reg_addr(addr),
    .i_reg_wdata(wdata), .i_reg_wr(wr), .i_reg_rd(rd), .o_reg_rdata(rdata),
    .i_interface_select_pin_hi(strap[1]), .i_interface_select_pin_lo(strap[0]),
    .o_spi_mode(spi),
    .i_output_multiplier_pll_locked(lock), .o_cal_start(cal_start), .o_cal_enabled(cal_en),
    .i_dpll_phase_lock(ph), .i_dpll_freq_lock(fr), .i_mfp_sync(mfp), .o_dist_release(rel),
    .o_rf_div_a(rfa), .o_rf_div_b(rfb), .o_chan_div(cdiv), .o_drv_en(drv),
    .i_irq_events(ev), .o_irq(irq), .o_irq_oe(irq_oe), .o_user_freerun(frun),
    .i_ref_valid(rvalid), .i_ref_priority(rprio), .o_active_ref(aref), .o_ref_acquired(acq),
    .i_holdover(hold), .i_sysclk_present(sysclk), .i_dco_tw(tw_in), .o_dco_tw(tw_out),
    .o_out_active(outact));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic rdchk(input logic [15:0] a, input logic [7:0] exp);
    i_ctrl_host.rd(a, d);
    chk(32'(d), 32'(exp));
  endtask : rdchk
  task automatic waitn(input int n);
    repeat (n) @(negedge clk);
  endtask : waitn
  task automatic evp(input int b);
    @(negedge clk);
    ev[b] = 1'b1;
    @(negedge clk);
    ev[b] = 1'b0;
  endtask : evp
  task automatic results();
    $display("checks=%0d mismatches=%0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : results
  initial
  begin
    repeat (20000) @(posedge clk);
    mismatches++;
    results();
  end
  initial
  begin
    waitn(2);
    rstn = 1'b1;
    rdchk(CTRL_LOOP_MODE_CONTROL, 8'h20);
    for (int i = 0; i < 6; i++) rdchk(CTRL_IRQ_MASK_BASE + 16'(i), 8'h00);
    rdchk(CTRL_IRQ_PIN_MODE, 8'h00);
    rdchk(CTRL_WDOG_LO, 8'h00);
    rdchk(CTRL_WDOG_HI, 8'h00);
    rdchk(16'h0fff, 8'h00);
    chk(spi, 1);
    chk(frun, 1);
    i_ctrl_host.wr(CTRL_OUTPUT_PLL_CALIBRATION, 8'h01);
    chk(cal_en, 0);
    rdchk(CTRL_OUTPUT_PLL_CALIBRATION, 8'h01);
    i_ctrl_host.upd();
    chk(cal_en, 1);
    chk(ncal, 1);
    rdchk(CTRL_UPDATE_TRANSFER, 8'h00);
    i_ctrl_host.upd();
    chk(ncal, 1);
    i_ctrl_host.cal();
    chk(ncal, 2);
    chk(cal_en, 1);
    lock = 1'b1;
    rdchk(CTRL_PLL_LOCK_STATUS, 8'h04);
    lock = 1'b0;
    rdchk(CTRL_PLL_LOCK_STATUS, 8'h00);
    i_ctrl_host.wr(CTRL_DISTRIBUTION_SYNC_CONTROL, 8'hf0);
    i_ctrl_host.upd();
    chk(drv, 0);
    i_ctrl_host.wr(CTRL_SOFT_SYNC_CONTROL, 8'h02);
    i_ctrl_host.wr(CTRL_SOFT_SYNC_CONTROL, 8'h00);
    waitn(2);
    chk(rel, 1);
    for (int c = 0; c < 4; c++)
    begin
      i_ctrl_host.wr(CTRL_DISTRIBUTION_SYNC_CONTROL, 8'h10 << c);
      i_ctrl_host.upd();
      chk(drv, DRV[c]);
    end
    for (int m = 1; m < 3; m++)
    begin
      i_ctrl_host.wr(CTRL_DISTRIBUTION_SYNC_CONTROL, 8'hf0 | 8'(m));
      i_ctrl_host.upd();
      ph = (m == 1);
      fr = (m == 2);
      waitn(2);
      chk(rel, 1);
      ph = 1'b0;
      fr = 1'b0;
      waitn(2);
      chk(rel, 0);
    end
    i_ctrl_host.wr(CTRL_DISTRIBUTION_SYNC_CONTROL, 8'hf3);
    i_ctrl_host.upd();
    chk(rel, 0);
    @(negedge clk);
    mfp = 1'b1;
    @(negedge clk);
    mfp = 1'b0;
    waitn(2);
    chk(rel, 1);
    // loop stays locked while the dividers change
    ph = 1'b1;
    i_ctrl_host.wr(16'h0501, 8'hf2);
    i_ctrl_host.wr(16'h0502, 8'hff);
    i_ctrl_host.wr(16'h0503, 8'h03);
    i_ctrl_host.upd();
    chk(rfa, 3);
    chk(rfb, 11);
    chk(cdiv[10:0], 11'h400);
    chk(cdiv[43:33], 1);
    i_ctrl_host.wr(CTRL_IRQ_MASK_BASE, 8'h01);
    i_ctrl_host.wr(16'h020f, 8'h01);
    i_ctrl_host.upd();
    evp(1);
    rdchk(CTRL_IRQ_MONITOR_BASE, 8'h00);
    evp(0);
    rdchk(CTRL_IRQ_MONITOR_BASE, 8'h01);
    chk(irq_oe, 1);
    chk(irq, 0);
    i_ctrl_host.wr(CTRL_IRQ_CLEAR_BASE, 8'h01);
    rdchk(CTRL_IRQ_MONITOR_BASE, 8'h00);
    evp(0);
    i_ctrl_host.wr(CTRL_GLOBAL_CLEAR_CONTROL, 8'h02);
    rdchk(CTRL_IRQ_MONITOR_BASE, 8'h00);
    chk(irq_oe, 0);
    i_ctrl_host.wr(CTRL_WDOG_LO, 8'h02);
    i_ctrl_host.upd();
    for (int i = 0; i < 5; i++)
    begin
      waitn(8);
      i_ctrl_host.wr(CTRL_GLOBAL_CLEAR_CONTROL, 8'h01);
    end
    rdchk(16'h0d07, 8'h00);
    waitn(40);
    rdchk(16'h0d07, 8'h01);
    // watchdog bit stays pending, so the PMOS and both push-pull pin modes show an active request
    for (int m = 1; m < 4; m++)
    begin
      i_ctrl_host.wr(CTRL_IRQ_PIN_MODE, 8'(m));
      i_ctrl_host.upd();
      chk({irq, irq_oe}, {m != 3, 1'b1});
    end
    i_ctrl_host.wr(CTRL_LOOP_MODE_CONTROL, 8'h00);
    chk(frun, 1);
    i_ctrl_host.upd();
    waitn(2);
    chk(frun, 0);
    chk(aref, 2);
    chk(acq, 1);
    chk(outact, 1);
    chk(tw_out, TW);
    hold = 1'b1;
    tw_in = 30'h0;
    waitn(4);
    // truncating average may settle a few counts under the input
    chk(tw_out <= TW && tw_out + 30'd32 > TW, 1);
    sysclk = 1'b0;
    waitn(2);
    chk(outact, 0);
    // second reset with a strap high selects the other serial protocol
    strap = 2'b01;
    rstn = 1'b0;
    waitn(2);
    rstn = 1'b1;
    waitn(2);
    chk(spi, 0);
    rdchk(CTRL_LOOP_MODE_CONTROL, 8'h20);
    results();
  end
endmodule : tb_top
